// ===== rtl/ppc_port_config.sv
// Module: general-purpose port pin control with APB register access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ppc_port_config (
  input wire logic clk, // 40 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped
  input wire logic expandedMode, // Expanded bus mode
  input wire logic peripheralMode, // Peripheral mode
  input wire logic emeSet, // Bus port emulation in expanded mode
  input wire logic [15:0] extBusOut, // Multiplexed bus drive value
  input wire logic extBusOe, // Multiplexed bus drives
  input wire logic [7:0] firstPortIn, // First port pin level
  output logic [7:0] firstPortOut, // First port pin drive
  output logic [7:0] firstPortOeN, // First port enable, low drives
  input wire logic [7:0] secondPortIn, // Second port pin level
  output logic [7:0] secondPortOut, // Second port pin drive
  output logic [7:0] secondPortOeN, // Second port enable, low drives
  input wire logic [7:0] busControlPortIn, // Bus control pin level
  output logic [7:0] busControlPortOut, // Bus control pin drive
  output logic [7:0] busControlPortOeN, // Bus control enable, low drives
  input wire logic [7:0] pwmPortIn, // PWM port pin level
  output logic [7:0] pwmPortOut, // PWM port pin drive
  output logic [7:0] pwmPortOeN, // PWM port enable, low drives
  input wire logic [7:0] timerPortIn, // Timer port pin level
  output logic [7:0] timerPortOut, // Timer port pin drive
  output logic [7:0] timerPortOeN, // Timer port enable, low drives
  input wire logic [7:0] serialPortIn, // Serial port pin level
  output logic [7:0] serialPortOut, // Serial port pin drive
  output logic [7:0] serialPortOeN, // Serial port enable, low drives
  input wire logic [6:2] canPortGpioIn, // CAN gpio pin level
  output logic [6:2] canPortGpioOut, // CAN gpio pin drive
  output logic [6:2] canPortGpioOeN, // CAN gpio enable, low drives
  input wire logic [7:0] analogPortIn, // Analog port digital level
  input wire logic adEnable, // Converter owns analog port
  input wire logic canTxd, // CAN controller transmit
  output logic canTransmitPin, // CAN transmit pin
  input wire logic canReceivePin, // CAN receive pin
  output logic canRxd, // Receive level to controller
  input wire logic [7:2] busCtlClaim, // Bus control function owns pin
  input wire logic [7:2] busCtlOut, // Bus control function drive
  input wire logic [7:2] busCtlOe, // Bus control function enable
  input wire logic [3:0] pwmChanEn, // PWM channel enables
  input wire logic [3:0] pwmOut, // PWM channel outputs
  input wire logic [7:0] timerClaim, // Timer owns pin
  input wire logic [7:0] timerOut, // Timer drive
  input wire logic [7:0] timerOe, // Timer enable
  input wire logic [7:0] serialClaim, // Serial interface owns pin
  input wire logic [7:0] serialOut, // Serial drive
  input wire logic [7:0] serialOe, // Serial enable
  output logic [7:0] firstPortPull, // First port pull-up active
  output logic [7:0] secondPortPull, // Second port pull-up active
  output logic [7:0] busControlPortPull, // Bus control pull-up active
  output logic [6:5] busControlPullDown, // Pull-down held during reset
  output logic [7:0] pwmPortPull, // PWM port pull-up active
  output logic [7:0] timerPortPull, // Timer port pull-up active
  output logic [7:0] serialPortPull, // Serial port pull-up active
  output logic [6:2] canPortPull, // CAN gpio pull-up active
  output logic canReceivePull, // Receive pin pull-up
  output logic debugPull, // Debug pin pull-up
  output logic firstPortLowDrive, // First port reduced drive
  output logic secondPortLowDrive, // Second port reduced drive
  output logic busPortLowDrive, // Bus control reduced drive
  output logic pwmPortLowDrive, // PWM port reduced drive
  output logic timerPortLowDrive, // Timer port reduced drive
  output logic [2:0] serialLowDrive, // Serial group reduced drive
  output logic canPortLowDrive // CAN gpio reduced drive
);
  import ppc_pkg::*;

  // ------------------------------------------------------------
  // Storage and helpers
  // ------------------------------------------------------------
  logic [7:0] aData, bData, eData, pData, tData, sData, cData;
  logic [7:0] aDir, bDir, eDir, pDir, tDir, sDir, cDir;
  logic [7:0] pullupReg, driveReg, pwmPad, tmrPad, serPad, canPad;
  logic drvLocked;
  logic busMode, eUnmapped, hit, wr;
  logic [9:0] idx;
  logic [7:0] rd, aOeN, bOeN, eOeN, pOeN, tOeN, sOeN, cOeN;
  logic [7:0] aOut, bOut, eOut, pOut, tOut, sOut, pClaim;

  function automatic logic [7:0] pinRead(input logic [7:0] d, input logic [7:0] dir,
                                         input logic [7:0] pin);
    pinRead = (d & dir) | (pin & ~dir);
  endfunction

  function automatic logic [7:0] pick(input logic [7:0] claim, input logic [7:0] per,
                                      input logic [7:0] own);
    pick = (claim & per) | (~claim & own);
  endfunction

  assign busMode = expandedMode | peripheralMode;
  assign eUnmapped = peripheralMode | (expandedMode & emeSet);
  assign idx = paddr[11:2];
  assign wr = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = {24'h000000, rd};

  // ------------------------------------------------------------
  // Address decode and read data
  // ------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd = 8'h00;
    case (idx)
      PPC_IDX_A_DATA: begin
        hit = ~busMode;
        rd = pinRead(aData, aDir, firstPortIn);
      end
      PPC_IDX_B_DATA: begin
        hit = ~busMode;
        rd = pinRead(bData, bDir, secondPortIn);
      end
      PPC_IDX_A_DIR: begin
        hit = ~busMode;
        rd = aDir;
      end
      PPC_IDX_B_DIR: begin
        hit = ~busMode;
        rd = bDir;
      end
      PPC_IDX_E_DATA: begin
        hit = ~eUnmapped;
        rd = pinRead(eData, eDir, busControlPortIn); // Low pins always read the pin
      end
      PPC_IDX_E_DIR: begin
        hit = ~eUnmapped;
        rd = eDir;
      end
      PPC_IDX_PULLUP: rd = pullupReg;
      PPC_IDX_DRIVE: begin
        hit = ~peripheralMode;
        rd = driveReg;
      end
      PPC_IDX_PWM_PAD: rd = pwmPad;
      PPC_IDX_P_DATA: rd = pinRead(pData, pDir, pwmPortIn);
      PPC_IDX_P_DIR: rd = pDir;
      PPC_IDX_AD_DATA: rd = adEnable ? 8'h00 : analogPortIn;
      PPC_IDX_TMR_PAD: rd = tmrPad;
      PPC_IDX_T_DATA: rd = pinRead(tData, tDir, timerPortIn);
      PPC_IDX_T_DIR: rd = tDir;
      PPC_IDX_S_DATA: rd = pinRead(sData, sDir, serialPortIn);
      PPC_IDX_S_DIR: rd = sDir;
      PPC_IDX_SER_PAD: rd = serPad;
      PPC_IDX_CAN_PAD: rd = canPad;
      PPC_IDX_C_DATA: rd = pinRead(cData, cDir, {1'b0, canPortGpioIn, 2'b00});
      PPC_IDX_C_DIR: rd = cDir;
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
    if (!hit) begin
      rd = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aData <= PPC_REG_RST;
      bData <= PPC_REG_RST;
      eData <= PPC_REG_RST;
      pData <= PPC_REG_RST;
      tData <= PPC_REG_RST;
      sData <= PPC_REG_RST;
      cData <= PPC_REG_RST;
    end else if (wr) begin
      if (idx == PPC_IDX_A_DATA) aData <= pwdata[7:0];
      if (idx == PPC_IDX_B_DATA) bData <= pwdata[7:0];
      if (idx == PPC_IDX_E_DATA) eData <= pwdata[7:0];
      if (idx == PPC_IDX_P_DATA) pData <= pwdata[7:0];
      if (idx == PPC_IDX_T_DATA) tData <= pwdata[7:0];
      if (idx == PPC_IDX_S_DATA) sData <= pwdata[7:0];
      if (idx == PPC_IDX_C_DATA) cData <= pwdata[7:0] & PPC_C_DIR_MASK;
    end
  end

  // ------------------------------------------------------------
  // Direction registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aDir <= PPC_REG_RST;
      bDir <= PPC_REG_RST;
      eDir <= PPC_REG_RST;
      pDir <= PPC_REG_RST;
      tDir <= PPC_REG_RST;
      sDir <= PPC_REG_RST;
      cDir <= PPC_REG_RST;
    end else if (wr) begin
      if (idx == PPC_IDX_A_DIR) aDir <= pwdata[7:0];
      if (idx == PPC_IDX_B_DIR) bDir <= pwdata[7:0];
      if (idx == PPC_IDX_E_DIR) eDir <= pwdata[7:0] & PPC_E_DIR_MASK;
      if (idx == PPC_IDX_P_DIR) pDir <= pwdata[7:0];
      if (idx == PPC_IDX_T_DIR) tDir <= pwdata[7:0];
      if (idx == PPC_IDX_S_DIR) sDir <= pwdata[7:0];
      if (idx == PPC_IDX_C_DIR) cDir <= pwdata[7:0] & PPC_C_DIR_MASK;
    end
  end

  // ------------------------------------------------------------
  // Pull-up and drive control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullupReg <= PPC_PULLUP_RST;
      driveReg <= PPC_REG_RST;
      drvLocked <= 1'b0;
      pwmPad <= PPC_REG_RST;
      tmrPad <= PPC_REG_RST;
      serPad <= PPC_REG_RST;
      canPad <= PPC_REG_RST;
    end else if (wr) begin
      if (idx == PPC_IDX_PULLUP) pullupReg <= pwdata[7:0] & PPC_PULLUP_MASK;
      // Later writes are accepted on the bus but leave the value alone
      if (idx == PPC_IDX_DRIVE && !drvLocked) begin
        driveReg <= pwdata[7:0] & PPC_DRIVE_MASK;
        drvLocked <= 1'b1;
      end
      if (idx == PPC_IDX_PWM_PAD) pwmPad <= pwdata[7:0] & PPC_PWM_MASK;
      if (idx == PPC_IDX_TMR_PAD) tmrPad <= pwdata[7:0] & PPC_TMR_MASK;
      if (idx == PPC_IDX_SER_PAD) serPad <= pwdata[7:0] & PPC_SER_MASK;
      if (idx == PPC_IDX_CAN_PAD) canPad <= pwdata[7:0] & PPC_CAN_MASK;
    end
  end

  // ------------------------------------------------------------
  // Pin ownership
  // ------------------------------------------------------------
  assign pClaim = {4'h0, pwmChanEn};
  assign aOut = busMode ? extBusOut[15:8] : aData;
  assign bOut = busMode ? extBusOut[7:0] : bData;
  assign aOeN = busMode ? {8{~extBusOe}} : ~aDir;
  assign bOeN = busMode ? {8{~extBusOe}} : ~bDir;
  assign eOut = pick({busCtlClaim, 2'b00}, {busCtlOut, 2'b00}, eData);
  assign eOeN = ~(pick({busCtlClaim, 2'b00}, {busCtlOe, 2'b00}, eDir) & PPC_E_DIR_MASK);
  assign pOut = pick(pClaim, {4'h0, pwmOut}, pData);
  assign pOeN = ~pick(pClaim, 8'hff, pDir);
  assign tOut = pick(timerClaim, timerOut, tData);
  assign tOeN = ~pick(timerClaim, timerOe, tDir);
  assign sOut = pick(serialClaim, serialOut, sData);
  assign sOeN = ~pick(serialClaim, serialOe, sDir);
  assign cOeN = ~(cDir & PPC_C_DIR_MASK);

  // ------------------------------------------------------------
  // Pad drive, registered
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      firstPortOut <= PPC_REG_RST;
      secondPortOut <= PPC_REG_RST;
      busControlPortOut <= PPC_REG_RST;
      pwmPortOut <= PPC_REG_RST;
      timerPortOut <= PPC_REG_RST;
      serialPortOut <= PPC_REG_RST;
      canPortGpioOut <= 5'h00;
      firstPortOeN <= PPC_OEN_RST;
      secondPortOeN <= PPC_OEN_RST;
      busControlPortOeN <= PPC_OEN_RST;
      pwmPortOeN <= PPC_OEN_RST;
      timerPortOeN <= PPC_OEN_RST;
      serialPortOeN <= PPC_OEN_RST;
      canPortGpioOeN <= 5'h1f;
      canTransmitPin <= 1'b1;
      canRxd <= 1'b1;
    end else begin
      firstPortOut <= aOut;
      secondPortOut <= bOut;
      busControlPortOut <= eOut;
      pwmPortOut <= pOut;
      timerPortOut <= tOut;
      serialPortOut <= sOut;
      canPortGpioOut <= cData[6:2];
      firstPortOeN <= aOeN;
      secondPortOeN <= bOeN;
      busControlPortOeN <= eOeN;
      pwmPortOeN <= pOeN;
      timerPortOeN <= tOeN;
      serialPortOeN <= sOeN;
      canPortGpioOeN <= cOeN[6:2];
      canTransmitPin <= canTxd;
      canRxd <= canReceivePin;
    end
  end

  // ------------------------------------------------------------
  // Pull-ups: only on pins that are not driving
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      firstPortPull <= PPC_REG_RST;
      secondPortPull <= PPC_REG_RST;
      busControlPortPull <= PPC_E_PULL_RST;
      busControlPullDown <= 2'b11;
      pwmPortPull <= PPC_REG_RST;
      timerPortPull <= PPC_REG_RST;
      serialPortPull <= PPC_REG_RST;
      canPortPull <= 5'h00;
    end else begin
      // Bus mode turns the first two ports' pull-ups off whatever the bit says
      firstPortPull <= {8{pullupReg[PPC_PU_A] & ~busMode}} & aOeN;
      secondPortPull <= {8{pullupReg[PPC_PU_B] & ~busMode}} & bOeN;
      busControlPortPull <= ({8{pullupReg[PPC_PU_E]}} & PPC_E_PULL_MASK & eOeN)
                            | PPC_E_PULL_FIXED;
      busControlPullDown <= 2'b00;
      pwmPortPull <= {8{pwmPad[PPC_PWM_PU]}} & pOeN;
      timerPortPull <= {8{tmrPad[PPC_TMR_PU]}} & tOeN;
      serialPortPull <= {{4{serPad[PPC_SER_PU + 2]}}, {2{serPad[PPC_SER_PU + 1]}},
                         {2{serPad[PPC_SER_PU]}}} & sOeN;
      canPortPull <= {5{canPad[PPC_CAN_PU]}} & cOeN[6:2];
    end
  end

  assign canReceivePull = 1'b1;
  assign debugPull = 1'b1;

  // ------------------------------------------------------------
  // Reduced drive
  // ------------------------------------------------------------
  assign firstPortLowDrive = driveReg[PPC_RD_A];
  assign secondPortLowDrive = driveReg[PPC_RD_B];
  assign busPortLowDrive = driveReg[PPC_RD_E];
  assign pwmPortLowDrive = pwmPad[PPC_PWM_RD];
  assign timerPortLowDrive = tmrPad[PPC_TMR_RD];
  assign serialLowDrive = serPad[PPC_SER_RD +: 3];
  assign canPortLowDrive = canPad[PPC_CAN_RD];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_bus_takes_pins: assert property (@(posedge clk) disable iff (sys_rst)
    busMode |=> firstPortOut == $past(extBusOut[15:8]) && secondPortOut == $past(extBusOut[7:0]))
    else $error("first ports not on external bus");
  a_data_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && busMode && paddr == 12'h004 |-> pslverr && prdata == 32'h0)
    else $error("second port data visible in bus mode");
  a_data_write: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && pwrite && !busMode && paddr == 12'h000 |=> aData == $past(pwdata[7:0]))
    else $error("first port data write lost");
  a_dir_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && busMode && (paddr == 12'h008 || paddr == 12'h00c) |-> pslverr)
    else $error("direction register visible in bus mode");
  a_can_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 canTransmitPin == $past(canTxd) && canRxd == $past(canReceivePin))
    else $error("CAN fixed pins not passed through");
  a_bus_low_input: assert property (@(posedge clk) disable iff (sys_rst)
    busControlPortOeN[1:0] == 2'b11 && eDir[1:0] == 2'b00)
    else $error("input-only bus pins driven");
  a_pwm_claims: assert property (@(posedge clk) disable iff (sys_rst)
    pwmChanEn[0] |=> pwmPortOeN[0] == 1'b0 && pwmPortOut[0] == $past(pwmOut[0]))
    else $error("enabled PWM channel lost its pin");
  a_pull_inputs: assert property (@(posedge clk) disable iff (sys_rst)
    (serialPortPull & ~serialPortOeN) == 8'h00 && (firstPortPull & ~firstPortOeN) == 8'h00)
    else $error("pull-up on a driving pin");
  a_dir_reset: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> aDir == 8'h00 && tDir == 8'h00 && driveReg == 8'h00)
    else $error("direction or drive not cleared by reset");
  a_drive_once: assert property (@(posedge clk) disable iff (sys_rst)
    drvLocked && wr && idx == PPC_IDX_DRIVE |=> $stable(driveReg))
    else $error("drive register written twice");
  a_pull_reset: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pullupReg == 8'h10 && busControlPullDown == 2'b11)
    else $error("pull reset state wrong");
endmodule
`default_nettype wire

// ===== include/ppc_pkg.sv
// Package: register indices, field positions and reset values of the port pad control block
package ppc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] PPC_IDX_A_DATA = 10'h000;
  localparam logic [9:0] PPC_IDX_B_DATA = 10'h001;
  localparam logic [9:0] PPC_IDX_A_DIR = 10'h002;
  localparam logic [9:0] PPC_IDX_B_DIR = 10'h003;
  localparam logic [9:0] PPC_IDX_E_DATA = 10'h008;
  localparam logic [9:0] PPC_IDX_E_DIR = 10'h009;
  localparam logic [9:0] PPC_IDX_PULLUP = 10'h00c;
  localparam logic [9:0] PPC_IDX_DRIVE = 10'h00d;
  localparam logic [9:0] PPC_IDX_PWM_PAD = 10'h054;
  localparam logic [9:0] PPC_IDX_P_DATA = 10'h056;
  localparam logic [9:0] PPC_IDX_P_DIR = 10'h057;
  localparam logic [9:0] PPC_IDX_AD_DATA = 10'h06f;
  localparam logic [9:0] PPC_IDX_TMR_PAD = 10'h08d;
  localparam logic [9:0] PPC_IDX_T_DATA = 10'h0ae;
  localparam logic [9:0] PPC_IDX_T_DIR = 10'h0af;
  localparam logic [9:0] PPC_IDX_S_DATA = 10'h0d6;
  localparam logic [9:0] PPC_IDX_S_DIR = 10'h0d7;
  localparam logic [9:0] PPC_IDX_SER_PAD = 10'h0db;
  localparam logic [9:0] PPC_IDX_CAN_PAD = 10'h13d;
  localparam logic [9:0] PPC_IDX_C_DATA = 10'h13e;
  localparam logic [9:0] PPC_IDX_C_DIR = 10'h13f;
  // Field positions
  localparam int PPC_PU_A = 0;
  localparam int PPC_PU_B = 1;
  localparam int PPC_PU_E = 4;
  localparam int PPC_RD_A = 0;
  localparam int PPC_RD_B = 1;
  localparam int PPC_RD_E = 3;
  localparam int PPC_PWM_PU = 1;
  localparam int PPC_PWM_RD = 2;
  localparam int PPC_TMR_RD = 4;
  localparam int PPC_TMR_PU = 5;
  localparam int PPC_SER_PU = 0;
  localparam int PPC_SER_RD = 4;
  localparam int PPC_CAN_RD = 0;
  localparam int PPC_CAN_PU = 1;
  // Writable masks and reset values
  localparam logic [7:0] PPC_PULLUP_MASK = 8'h13;
  localparam logic [7:0] PPC_DRIVE_MASK = 8'h0b;
  localparam logic [7:0] PPC_PWM_MASK = 8'h1f;
  localparam logic [7:0] PPC_TMR_MASK = 8'h30;
  localparam logic [7:0] PPC_SER_MASK = 8'h77;
  localparam logic [7:0] PPC_CAN_MASK = 8'h03;
  localparam logic [7:0] PPC_E_DIR_MASK = 8'hfc;
  localparam logic [7:0] PPC_C_DIR_MASK = 8'h7c;
  localparam logic [7:0] PPC_PULLUP_RST = 8'h10;
  localparam logic [7:0] PPC_REG_RST = 8'h00;
  localparam logic [7:0] PPC_OEN_RST = 8'hff;
  localparam logic [7:0] PPC_E_PULL_MASK = 8'h8d;
  localparam logic [7:0] PPC_E_PULL_FIXED = 8'h02;
  localparam logic [7:0] PPC_E_PULL_RST = 8'h8f;
endpackage

// ===== tb/ppc_pin_model.sv
// Board side of the port pads
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_model #(parameter int W = 8) (
  input wire logic [W-1:0] oeN, // Low while pad drives
  input wire logic [W-1:0] out, // Pad drive value
  input wire logic [W-1:0] pull, // Pull-up active
  input wire logic [W-1:0] ext, // Board level on released pins, set once by the bench
  output logic [W-1:0] pin // Resolved level
);
  // Released pins never hold the last driven value
  assign pin = (~oeN & out) | (oeN & (pull | ext));
endmodule
`default_nettype wire

// ===== tb/test_port_pin_config_summary.sv
// Bench for the port pad control block
`timescale 1ns/10ps
`default_nettype none
module test_port_pin_config_summary;
  import ppc_pkg::*;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic expandedMode = 0, peripheralMode = 0, emeSet = 0, extBusOe = 0, adEnable = 0;
  logic canTxd = 1, canReceivePin = 1, canTransmitPin, canRxd, canReceivePull, debugPull;
  logic firstPortLowDrive, secondPortLowDrive, busPortLowDrive, pwmPortLowDrive;
  logic timerPortLowDrive, canPortLowDrive;
  logic [2:0] serialLowDrive;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [15:0] extBusOut = 0;
  logic [7:0] ext = 0, analogPortIn = 0, timerClaim = 0, timerOut = 0, timerOe = 0, d;
  logic [7:0] serialClaim = 0, serialOut = 0, serialOe = 0;
  logic [7:0] firstPortIn, firstPortOut, firstPortOeN, firstPortPull;
  logic [7:0] secondPortIn, secondPortOut, secondPortOeN, secondPortPull;
  logic [7:0] busControlPortIn, busControlPortOut, busControlPortOeN, busControlPortPull;
  logic [7:0] pwmPortIn, pwmPortOut, pwmPortOeN, pwmPortPull;
  logic [7:0] timerPortIn, timerPortOut, timerPortOeN, timerPortPull;
  logic [7:0] serialPortIn, serialPortOut, serialPortOeN, serialPortPull;
  logic [6:2] canPortGpioIn, canPortGpioOut, canPortGpioOeN, canPortPull;
  logic [7:2] busCtlClaim = 0, busCtlOut = 0, busCtlOe = 0;
  logic [6:5] busControlPullDown;
  logic [3:0] pwmChanEn = 0, pwmOut = 0;
  logic [7:0] mdl [logic [9:0]];
  int failures = 0, num_checks = 0;
  logic [9:0] regs [12] = '{PPC_IDX_A_DIR, PPC_IDX_B_DIR, PPC_IDX_E_DIR, PPC_IDX_PULLUP,
    PPC_IDX_PWM_PAD, PPC_IDX_P_DIR, PPC_IDX_TMR_PAD, PPC_IDX_T_DIR, PPC_IDX_S_DIR,
    PPC_IDX_SER_PAD, PPC_IDX_CAN_PAD, PPC_IDX_C_DIR};
  logic [7:0] msk [12] = '{8'hff, 8'hff, PPC_E_DIR_MASK, PPC_PULLUP_MASK, PPC_PWM_MASK, 8'hff,
    PPC_TMR_MASK, 8'hff, 8'hff, PPC_SER_MASK, PPC_CAN_MASK, PPC_C_DIR_MASK};
  always #12.5 clk = ~clk;
  ppc_port_config i_ppc_port_config (.*);
  ppc_pin_model #(.W(53)) i_ppc_pin_model (
    .oeN({firstPortOeN, secondPortOeN, busControlPortOeN, pwmPortOeN, timerPortOeN,
      serialPortOeN, canPortGpioOeN}),
    .out({firstPortOut, secondPortOut, busControlPortOut, pwmPortOut, timerPortOut,
      serialPortOut, canPortGpioOut}),
    .pull({firstPortPull, secondPortPull, busControlPortPull, pwmPortPull, timerPortPull,
      serialPortPull, canPortPull}),
    .ext({ext, ~ext, ext, ~ext, ext, ~ext, ext[4:0]}),
    .pin({firstPortIn, secondPortIn, busControlPortIn, pwmPortIn, timerPortIn,
      serialPortIn, canPortGpioIn}));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      disable run_tests;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] v, input logic [7:0] m);
    apb(1'b1, i, v);
    chk(rerr, 1'b0);
    mdl[i] = v & m;
  endtask
  task automatic rd(input logic [9:0] i);
    apb(1'b0, i, 8'h00);
    chk(rdat, {24'h000000, mdl[i]});
  endtask
  task automatic bad(input logic w, input logic [9:0] i);
    apb(w, i, 8'hff);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
  endtask
  task automatic results();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    void'($urandom(32'he58ecb79));
    run_tests();
    results();
  end
  // A timed-out transfer stops this task and falls through to the verdict
  task automatic run_tests();
    repeat (10) @(posedge clk);
    chk({busControlPullDown, canReceivePull, debugPull}, 4'hf);
    sys_rst <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      mdl[regs[k]] = (regs[k] == PPC_IDX_PULLUP) ? PPC_PULLUP_RST : PPC_REG_RST;
      rd(regs[k]);
    end
    chk({busControlPullDown, busControlPortPull}, {2'b00, PPC_E_PULL_RST});
    mdl[PPC_IDX_DRIVE] = 8'h00;
    rd(PPC_IDX_DRIVE);
    for (int k = 0; k < 12; k++) begin
      wr(regs[k], 8'($urandom), msk[k]);
      rd(regs[k]);
    end
    d = mdl[PPC_IDX_A_DIR];
    chk(firstPortOeN, 8'(~d));
    chk(busControlPortOeN, 8'(~mdl[PPC_IDX_E_DIR]));
    chk(canPortGpioOeN, 5'(~mdl[PPC_IDX_C_DIR][6:2]));
    chk(firstPortPull, 8'(~d & {8{mdl[PPC_IDX_PULLUP][PPC_PU_A]}}));
    chk(serialLowDrive, mdl[PPC_IDX_SER_PAD][6:4]);
    chk(pwmPortLowDrive, mdl[PPC_IDX_PWM_PAD][PPC_PWM_RD]);
    wr(PPC_IDX_DRIVE, 8'hff, PPC_DRIVE_MASK);
    apb(1'b1, PPC_IDX_DRIVE, 8'h00);
    chk(rerr, 1'b0);
    rd(PPC_IDX_DRIVE);
    chk({busPortLowDrive, secondPortLowDrive, firstPortLowDrive}, 3'b111);
    wr(PPC_IDX_PULLUP, 8'h00, PPC_PULLUP_MASK);
    ext <= 8'($urandom);
    analogPortIn <= 8'($urandom);
    wr(PPC_IDX_A_DATA, 8'h5a, 8'hff);
    apb(1'b0, PPC_IDX_A_DATA, 8'h00);
    chk(rdat, {24'h0, (8'h5a & d) | (ext & ~d)});
    apb(1'b0, PPC_IDX_AD_DATA, 8'h00);
    chk(rdat, {24'h0, analogPortIn});
    pwmChanEn <= 4'hf;
    pwmOut <= 4'($urandom);
    timerClaim <= 8'hff;
    timerOe <= 8'($urandom);
    canTxd <= 1'b0;
    expandedMode <= 1'b1;
    extBusOe <= 1'b1;
    extBusOut <= 16'($urandom);
    serialClaim <= 8'hff;
    serialOe <= 8'($urandom);
    busCtlClaim <= 6'h3f;
    busCtlOe <= 6'($urandom);
    adEnable <= 1'b1;
    bad(1'b0, PPC_IDX_A_DATA);
    bad(1'b1, PPC_IDX_B_DIR);
    bad(1'b1, PPC_IDX_B_DATA);
    chk(serialPortOeN, 8'(~serialOe));
    chk(busControlPortOeN, 8'(~{busCtlOe, 2'b00}));
    apb(1'b0, PPC_IDX_AD_DATA, 8'h00);
    chk(rdat, 32'h0);
    rd(PPC_IDX_E_DIR);
    emeSet <= 1'b1;
    bad(1'b0, PPC_IDX_E_DIR);
    chk({pwmPortOeN[3:0], pwmPortOut[3:0]}, {4'h0, pwmOut});
    chk(timerPortOeN, 8'(~timerOe));
    chk({canTransmitPin, firstPortOeN}, 9'h0);
    chk({firstPortOut, secondPortOut}, extBusOut);
    expandedMode <= 1'b0;
    peripheralMode <= 1'b1;
    bad(1'b1, PPC_IDX_DRIVE);
    bad(1'b0, 10'h004);
  endtask
endmodule
`default_nettype wire
